// [hdl/wcc_crc_if.sv]
/*
  Carrier between the frame checker and one checksum tree.
  Assumes the user side holds data and received code stable while it reads.
*/
`timescale 1ns/1ps
interface wcc_crc_if;
  logic [71:0] data;
  logic [7:0] received;
  logic [7:0] computed;
  logic mismatch;

  modport tree (input data, input received, output computed, output mismatch);
  modport user (output data, output received, input computed, input mismatch);
endinterface

// [hdl/wcc_crc_tree.sv]
/*
  One eight-bit checksum tree over a 72-bit code word, purely combinational.
  Assumes the caller has already forced unused inputs to ones.
*/
`timescale 1ns/1ps
module wcc_crc_tree (
  wcc_crc_if.tree port
);
  import wcc_pkg::*;

  // ==========================================================================
  // Serial form unrolled by the tool; same result as the flat XOR equations
  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    logic fb;
    c = '0;
    fb = 1'b0;
    for (int i = TREE_BITS - 1; i >= 0; i--) begin
      fb = c[CRC_W-1] ^ d[i];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  always_comb begin
    port.computed = crc8(port.data);
    port.mismatch = (port.computed != port.received);
  end

endmodule

// [hdl/wcc_frame_check.sv]
/*
  Write-frame checksum checker of a x4/x8/x16 memory device: captures ten
  beats per frame from the data and mask/inversion lanes, checks them with
  two checksum trees, pulses the open-drain alert line and keeps sticky flags.
  Assumes the link strobe, frame and lane pins are asynchronous to CLOCK and
  that software reaches the registers over APB.
*/
`timescale 1ns/1ps

module wcc_frame_check (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic LINK_CLK,
  input wire logic FRAME,
  input wire logic CHOP,
  input wire logic COL_A2,
  input wire logic [15:0] DQ,
  input wire logic LOWER_INVERSION_LANE,
  input wire logic UPPER_INVERSION_LANE,
  output logic ALERT_N_O,
  output logic ALERT_N_OE
);
  import wcc_pkg::*;

  localparam int SYNC_W = LANES + 4;

  // ==========================================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic link_prev;
  logic link_edge;
  logic frame_s;
  logic chop_s;
  logic a2_s;
  logic [LANES-1:0] lane_in;

  assign pins_raw = {FRAME, CHOP, COL_A2, LINK_CLK, UPPER_INVERSION_LANE, DQ[15:8],
                     LOWER_INVERSION_LANE, DQ[7:0]};

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      sync1 <= '0;
      sync2 <= '0;
      link_prev <= 1'b0;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      link_prev <= sync2[LANES];
    end
  end

  // Both strobe edges carry a beat
  assign link_edge = sync2[LANES] ^ link_prev;
  assign frame_s = sync2[LANES+3];
  assign chop_s = sync2[LANES+2];
  assign a2_s = sync2[LANES+1];
  assign lane_in = sync2[LANES-1:0];

  // ==========================================================================
  // Registers
  logic [6:0] ctrl;
  logic clear_flag;
  logic mpr_status;
  logic [15:0] last_computed;
  logic [15:0] last_received;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  wcc_width_t width;
  logic mask_en;

  assign width = wcc_width_t'(ctrl[CTRL_WIDTH_HI:CTRL_WIDTH_LO]);
  // Either function opens the mask lane; both at once is not expected
  assign mask_en = ctrl[CTRL_DBI_EN] | ctrl[CTRL_DM_EN];
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign mapped = (PADDR == REG_CTRL) | (PADDR == REG_MODE5) | (PADDR == REG_MPR) |
                  (PADDR == REG_LAST);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl <= CTRL_RESET;
    end else if (wr_en && PADDR == REG_CTRL) begin
      ctrl <= PWDATA[6:0];
    end
  end

  // Read data is loaded in the setup cycle so it comes from a flop
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      PRDATA <= '0;
    end else if (rd_setup) begin
      case (PADDR)
        REG_CTRL: PRDATA <= {25'h0, ctrl};
        REG_MODE5: PRDATA <= 32'(clear_flag) << MODE5_CLR_BIT;
        REG_MPR: PRDATA <= 32'(mpr_status) << MPR_STATUS_BIT;
        REG_LAST: PRDATA <= {last_received, last_computed};
        default: PRDATA <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Frame capture
  wcc_state_t state;
  wcc_state_t next_state;
  logic [3:0] beat;
  logic chop;
  logic a2;
  logic [7:0] lane_bits [LANES];
  logic [1:0] crc_rx [LANES];
  logic [2:0] slot;
  logic start;
  logic capture_edge;
  logic crc_error;

  function automatic logic lane_used(input int k, input wcc_width_t w, input logic m);
    logic used;
    used = 1'b0;
    if (k == LOWER_MASK_LANE) begin
      used = m && (w != WCC_X4);
    end else if (k == UPPER_MASK_LANE) begin
      used = m && (w == WCC_X16);
    end else begin
      case (w)
        WCC_X4: used = (k < 4);
        WCC_X8: used = (k < LOWER_MASK_LANE);
        WCC_X16: used = 1'b1;
        default: used = 1'b0;
      endcase
    end
    return used;
  endfunction

  assign start = (state == WCC_IDLE) && frame_s && ctrl[CTRL_CRC_EN];
  assign capture_edge = (state == WCC_CAPTURE) && link_edge;
  assign slot = beat[2:0] + ((chop && a2) ? UPPER_HALF : 3'h0);

  always_comb begin
    next_state = state;
    case (state)
      WCC_IDLE: if (start) next_state = WCC_CAPTURE;
      WCC_CAPTURE: begin
        if (!frame_s) begin
          next_state = WCC_IDLE;
        end else if (capture_edge && beat == FRAME_BEATS - 4'h1) begin
          next_state = WCC_CHECK;
        end
      end
      WCC_CHECK: next_state = WCC_WAIT_END;
      WCC_WAIT_END: if (!frame_s) next_state = WCC_IDLE;
      default: next_state = WCC_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state <= WCC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Burst kind is fixed at frame start, per command when on-the-fly is set
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      beat <= '0;
      chop <= 1'b0;
      a2 <= 1'b0;
    end else if (start) begin
      beat <= '0;
      chop <= ctrl[CTRL_OTF_EN] ? chop_s : ctrl[CTRL_CHOP];
      a2 <= a2_s;
    end else if (capture_edge) begin
      beat <= beat + 4'h1;
    end
  end

  // Unused inputs stay at the all-ones value loaded at frame start
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
        lane_bits[k] <= LANE_ONES;
        crc_rx[k] <= 2'b11;
      end else if (start) begin
        lane_bits[k] <= LANE_ONES;
        crc_rx[k] <= 2'b11;
      end else if (capture_edge && lane_used(k, width, mask_en)) begin
        if (beat < DATA_BEATS && (!chop || beat < CHOP_BEATS)) begin
          lane_bits[k][slot] <= lane_in[k];
        end
        if (beat == CRC_BEAT_LO) begin
          crc_rx[k][0] <= lane_in[k];
        end
        if (beat == CRC_BEAT_HI) begin
          crc_rx[k][1] <= lane_in[k];
        end
      end
    end
  end

  // ==========================================================================
  // Checksum trees
  wcc_crc_if lower_if ();
  wcc_crc_if upper_if ();
  logic [7:0] rx_lower;
  logic [7:0] rx_upper;

  always_comb begin
    rx_lower = '0;
    rx_upper = '0;
    for (int n = 0; n < 4; n++) begin
      rx_lower[n] = crc_rx[n][0];
      rx_lower[n+4] = (width == WCC_X4) ? crc_rx[n][1] : crc_rx[n+4][0];
    end
    for (int n = 0; n < CRC_W; n++) begin
      rx_upper[n] = crc_rx[n+LOWER_MASK_LANE+1][0];
    end
  end

  for (genvar k = 0; k < LOWER_MASK_LANE + 1; k++) begin : g_flat
    assign lower_if.data[8*k+7:8*k] = lane_bits[k];
    assign upper_if.data[8*k+7:8*k] = lane_bits[k+LOWER_MASK_LANE+1];
  end
  assign lower_if.received = rx_lower;
  assign upper_if.received = rx_upper;

  wcc_crc_tree u_lower_tree (
    .port(lower_if)
  );

  wcc_crc_tree u_upper_tree (
    .port(upper_if)
  );

  // Array writes are not held back for this result; a retry overwrites
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      crc_error <= 1'b0;
      last_computed <= '0;
      last_received <= '0;
    end else if (state == WCC_CHECK) begin
      crc_error <= lower_if.mismatch | ((width == WCC_X16) & upper_if.mismatch);
      last_computed <= {upper_if.computed, lower_if.computed};
      last_received <= {rx_upper, rx_lower};
    end else begin
      crc_error <= 1'b0;
    end
  end

  // ==========================================================================
  // Sticky flags: a new error wins over a software clear in the same cycle
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      clear_flag <= 1'b0;
    end else if (crc_error) begin
      clear_flag <= 1'b1;
    end else if (wr_en && PADDR == REG_MODE5) begin
      clear_flag <= PWDATA[MODE5_CLR_BIT];
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      mpr_status <= 1'b0;
    end else if (crc_error) begin
      mpr_status <= 1'b1;
    end else if (wr_en && PADDR == REG_MPR && !PWDATA[MPR_STATUS_BIT]) begin
      mpr_status <= 1'b0;
    end
  end

  // ==========================================================================
  // Alert pulse on the shared open-drain line
  logic [3:0] alert_cnt;

  // Errors during a pulse merge into it so no pulse exceeds the maximum width
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      ALERT_N_OE <= 1'b0;
      alert_cnt <= '0;
    end else if (crc_error && !ALERT_N_OE) begin
      ALERT_N_OE <= 1'b1;
      alert_cnt <= ALERT_PW_CYC - 4'h1;
    end else if (ALERT_N_OE) begin
      if (alert_cnt == 4'h0) begin
        ALERT_N_OE <= 1'b0;
      end else begin
        alert_cnt <= alert_cnt - 4'h1;
      end
    end
  end

  assign ALERT_N_O = 1'b0;

  // ==========================================================================
  // Assertions
  a_pulse_min: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(ALERT_N_OE) |-> ALERT_N_OE [*6])
    else $error("alert pulse shorter than six clocks");

  a_pulse_max: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(ALERT_N_OE) |-> ##[6:10] !ALERT_N_OE)
    else $error("alert pulse longer than ten clocks");

  a_alert_latency: assert property (@(posedge CLOCK) disable iff (!RSTN)
    crc_error |-> ##[1:2] ALERT_N_OE)
    else $error("alert not driven within latency");

  a_alert_cause: assert property (@(posedge CLOCK) disable iff (!RSTN)
    $rose(ALERT_N_OE) |-> $past(crc_error))
    else $error("alert pulse without checksum error");

  a_flags_set: assert property (@(posedge CLOCK) disable iff (!RSTN)
    crc_error |=> clear_flag && mpr_status)
    else $error("error flags not set");

  a_flag_sticky: assert property (@(posedge CLOCK) disable iff (!RSTN)
    clear_flag && !(wr_en && PADDR == REG_MODE5) |=> clear_flag)
    else $error("clear flag dropped without software write");

  a_frame_length: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state == WCC_CHECK |-> beat == FRAME_BEATS && $past(state) == WCC_CAPTURE)
    else $error("frame checked at wrong length");

  a_upper_tree: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state == WCC_CHECK && width == WCC_X16 && upper_if.mismatch |=> crc_error)
    else $error("upper tree mismatch not reported");

  a_mask_ones: assert property (@(posedge CLOCK) disable iff (!RSTN)
    state == WCC_CHECK && !mask_en |-> lower_if.data[71:64] == LANE_ONES &&
      upper_if.data[71:64] == LANE_ONES)
    else $error("mask inputs not forced to ones");

endmodule

// [hdl/wcc_pkg.sv]
/*
  Shared constants and types for the write-frame checksum checker: register
  map, control field layout, frame beat positions, checksum code and alert
  timing. Assumes a 200 MHz core clock, which is also the command clock.
*/
package wcc_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE5 = 8'h04;
  localparam logic [7:0] REG_MPR = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0C;

  localparam int CTRL_CRC_EN = 0;
  localparam int CTRL_DBI_EN = 1;
  localparam int CTRL_DM_EN = 2;
  localparam int CTRL_OTF_EN = 3;
  localparam int CTRL_CHOP = 4;
  localparam int CTRL_WIDTH_LO = 5;
  localparam int CTRL_WIDTH_HI = 6;
  localparam logic [6:0] CTRL_RESET = 7'h40;
  localparam int MODE5_CLR_BIT = 3;
  localparam int MPR_STATUS_BIT = 0;

  // ==========================================================================
  // Frame layout
  localparam int LANES = 18;
  localparam int LOWER_MASK_LANE = 8;
  localparam int UPPER_MASK_LANE = 17;
  localparam logic [3:0] FRAME_BEATS = 4'hA;
  localparam logic [3:0] DATA_BEATS = 4'h8;
  localparam logic [3:0] CHOP_BEATS = 4'h4;
  localparam logic [3:0] CRC_BEAT_LO = 4'h8;
  localparam logic [3:0] CRC_BEAT_HI = 4'h9;
  localparam logic [2:0] UPPER_HALF = 3'h4;
  localparam logic [7:0] LANE_ONES = 8'hFF;

  // ==========================================================================
  // Checksum code
  localparam int TREE_BITS = 72;
  localparam int CRC_W = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // ==========================================================================
  // Alert timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ALERT_LAT_NS = 13;
  localparam int ALERT_LAT_CYC = (ALERT_LAT_NS * 1000) / CLK_PERIOD_PS;
  localparam int ALERT_PW_MIN = 6;
  localparam int ALERT_PW_MAX = 10;
  localparam logic [3:0] ALERT_PW_CYC = 4'h8;

  typedef enum logic [1:0] {
    WCC_X4 = 2'b00,
    WCC_X8 = 2'b01,
    WCC_X16 = 2'b10
  } wcc_width_t;

  typedef enum logic [1:0] {
    WCC_IDLE = 2'b00,
    WCC_CAPTURE = 2'b01,
    WCC_CHECK = 2'b10,
    WCC_WAIT_END = 2'b11
  } wcc_state_t;

endpackage

// [sim/testbench.sv]
/*
  Self-checking bench for the write-frame checker: APB master tasks, a
  controller model on the link pins and a pull-up on the alert line.
  Assumes zero-wait APB and the frame timing of the controller model.
*/
`timescale 1ns/1ps
module testbench;
  import wcc_pkg::*;
  logic CLOCK = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, ALERT_N_O, ALERT_N_OE;
  wire link_clk, frame, chop, col_a2;
  wire [17:0] lanes;
  // Open-drain line with the controller's pull-up
  wire alert_line = (ALERT_N_OE === 1'b1) ? ALERT_N_O : 1'b1;
  int fails = 0, checks_done = 0, pulses = 0, low_cnt = 0, width = 0;
  realtime fall_t = 0;
  logic [31:0] rd;
  logic err;
  logic [8:0] cf;
  logic ch;
  logic [9:0][17:0] bt;
  logic [1:0][71:0] d;
  logic [1:0][7:0] crc;
  // {a2, chop pin, ctrl}; inversion and masking never both on
  localparam logic [8:0] CFG [11] = '{9'h041, 9'h043, 9'h025, 9'h001, 9'h111, 9'h035,
    9'h1AB, 9'h0CD, 9'h049, 9'h151, 9'h040};

  always #2.5 CLOCK = ~CLOCK;

  wcc_frame_check i_wcc_frame_check (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_CLK(link_clk), .FRAME(frame), .CHOP(chop),
    .COL_A2(col_a2), .DQ(lanes[15:0]), .LOWER_INVERSION_LANE(lanes[16]),
    .UPPER_INVERSION_LANE(lanes[17]), .ALERT_N_O(ALERT_N_O), .ALERT_N_OE(ALERT_N_OE));

  wcc_ctrl_model i_wcc_ctrl_model (.link_clk(link_clk), .frame(frame), .chop(chop),
    .col_a2(col_a2), .lanes(lanes));

  // ==========================================================================
  // Alert pulse monitor
  always @(posedge CLOCK) begin
    if (alert_line === 1'b0) begin
      if (low_cnt == 0) begin
        fall_t <= $realtime;
        pulses <= pulses + 1;
      end
      low_cnt <= low_cnt + 1;
    end else if (low_cnt != 0) begin
      width <= low_cnt;
      low_cnt <= 0;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  function automatic logic [7:0] crc8(input logic [71:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  // Unused lanes keep a changing pattern that the checker must ignore
  task automatic build(input logic [6:0] ctrl, input logic a2, input int seed);
    int lb, ix, nl;
    logic use_m, used;
    use_m = ctrl[1] | ctrl[2];
    nl = ctrl[6] ? 16 : ctrl[5] ? 8 : 4;
    for (int t = 0; t < 10; t++)
      for (int b = 0; b < 18; b++)
        bt[t][b] = ((t * 7 + b * 3 + seed) % 5) < 2;
    d = '1;
    for (int k = 0; k < 2; k++)
      for (int l = 0; l < 9; l++)
        for (int t = 0; t < 8; t++) begin
          lb = (l == 8) ? 16 + k : 8 * k + l;
          ix = 8 * l + t + ((ch && a2) ? 4 : 0);
          used = (l < 8) ? (lb < nl) : (use_m && (k == 0 ? nl > 4 : nl == 16));
          if (used && ch && t > 3) bt[t][lb] = 1'b1;
          else if (used) d[k][ix] = bt[t][lb];
        end
    for (int k = 0; k < 2; k++) crc[k] = crc8(d[k]);
    for (int b = 0; b < 18; b++) begin
      if (b < nl) begin
        bt[8][b] = crc[b / 8][b % 8];
        bt[9][b] = (nl == 4) ? crc[0][b + 4] : 1'b1;
      end else if (b > 15 && use_m && (b == 16 ? nl > 4 : nl == 16)) begin
        bt[8][b] = 1'b1;
        bt[9][b] = 1'b1;
      end
    end
  endtask

  task automatic send_chk(input int exp, input int edges, input int flip);
    int p0;
    logic [9:0][17:0] b;
    p0 = pulses;
    b = bt;
    if (flip >= 0) b[0][flip] = ~b[0][flip];
    i_wcc_ctrl_model.send(b, cf[7], cf[8], edges);
    repeat (20) @(posedge CLOCK);
    check("pulses", pulses - p0, exp);
    if (exp != 0) begin
      check("width", width, ALERT_PW_CYC);
      check("latency", (fall_t - i_wcc_ctrl_model.last_edge_t) <= 35.0, 1);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    repeat (4) @(posedge CLOCK);
    RSTN <= 1'b1;
    apb(0, REG_CTRL, 0);
    check("ctrl", rd, {25'h0, CTRL_RESET});
    apb(0, REG_MODE5, 0);
    check("mode5", rd, 0);
    apb(0, 8'h10, 0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 11; i++) begin
      cf = CFG[i];
      ch = cf[3] ? cf[7] : cf[4];
      apb(1, REG_CTRL, {25'h0, cf[6:0]});
      build(cf[6:0], cf[8], i);
      send_chk(0, 10, -1);
      apb(0, REG_LAST, 0);
      if (cf[0]) check("last_lo", rd & 32'h00FF00FF, {8'h0, crc[0], 8'h0, crc[0]});
      if (cf[0] & cf[6]) check("last_hi", rd & 32'hFF00FF00, {crc[1], 8'h0, crc[1], 8'h0});
      send_chk(cf[0], 10, cf[6] ? 8 : 0);
      // Controller retries the failed write; the clean copy raises no alert
      send_chk(0, 10, -1);
      apb(0, REG_MODE5, 0);
      check("mode5_flag", rd[MODE5_CLR_BIT], cf[0]);
      apb(0, REG_MPR, 0);
      check("mpr_flag", rd[MPR_STATUS_BIT], cf[0]);
      apb(1, REG_MODE5, 0);
      apb(1, REG_MPR, 0);
      apb(0, REG_MODE5, 0);
      check("mode5_clr", rd[MODE5_CLR_BIT], 0);
      apb(0, REG_MPR, 0);
      check("mpr_clr", rd[MPR_STATUS_BIT], 0);
      $display("test %0d done", i);
    end
    cf = CFG[0];
    ch = 1'b0;
    apb(1, REG_CTRL, {25'h0, cf[6:0]});
    build(cf[6:0], 1'b0, 3);
    send_chk(0, 6, 0);
    send_chk(1, 10, 0);
    $display("test abort done");
    summarize();
  end

  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule

// [sim/wcc_ctrl_model.sv]
/*
  Memory controller model: serialises one write frame onto the link pins.
  Assumes the bench has built every beat; lanes[15:0] are data, 16 and 17
  the lower and upper mask/inversion lanes.
*/
`timescale 1ns/1ps
module wcc_ctrl_model (
  output logic link_clk,
  output logic frame,
  output logic chop,
  output logic col_a2,
  output logic [17:0] lanes
);
  realtime last_edge_t;

  initial begin
    link_clk = 1'b0;
    frame = 1'b0;
    chop = 1'b0;
    col_a2 = 1'b0;
    lanes = 18'h2AAAA;
    last_edge_t = 0;
  end

  // ==========================================================================
  // Frame driver
  // Data changes midway between strobe edges so the synchronised edge sees it
  task automatic send(input logic [9:0][17:0] beats, input logic c, input logic a,
                      input int edges);
    chop = c;
    col_a2 = a;
    frame = 1'b1;
    #30;
    for (int t = 0; t < edges; t++) begin
      lanes = beats[t];
      #12;
      link_clk = ~link_clk;
      last_edge_t = $realtime;
      #12;
    end
    #40;
    frame = 1'b0;
    // Released lanes show no stale value; strobe stands still between frames
    lanes = ~lanes;
  endtask
endmodule
